/* File: design/scc_defs.vh */
`ifndef SCC_DEFS_VH
`define SCC_DEFS_VH
// ==========================================
// Clock divider
`define SCC_OSC_MHZ 100
`define SCC_E_DIV 4
`define SCC_PHASE_LAST 2'h3
// ==========================================
// Register bus byte offsets
`define SCC_OFS_CMD 8'h00
`define SCC_OFS_ACC 8'h04
`define SCC_OFS_FLAGS 8'h08
`define SCC_OFS_SP 8'h0C
`define SCC_OFS_INDEX 8'h10
`define SCC_OFS_RDATA 8'h14
// ==========================================
// Commands
`define SCC_OP_NOP 4'h0
`define SCC_OP_PUSH_A 4'h1
`define SCC_OP_PUSH_B 4'h2
`define SCC_OP_PULL_A 4'h3
`define SCC_OP_PULL_B 4'h4
`define SCC_OP_ADD 4'h5
`define SCC_OP_SUB 4'h6
`define SCC_OP_LOAD 4'h7
`define SCC_OP_STORE 4'h8
`define SCC_OP_JUMP 4'h9
`define SCC_OP_STEP 4'hA
`define SCC_OP_WAIT 4'hB
`define SCC_OP_CLI 4'hC
`define SCC_OP_SEI 4'hD
// ==========================================
// Vectors and reset values
`define SCC_VEC_IRQ 16'hFFF8
`define SCC_VEC_NMI 16'hFFFC
`define SCC_VEC_RST 16'hFFFE
`define SCC_SP_RST 16'h0000
`define SCC_FLAGS_RST 8'hD0
`define SCC_FLAGS_ONES 8'hC0
`define SCC_FLAG_C 0
`define SCC_FLAG_V 1
`define SCC_FLAG_Z 2
`define SCC_FLAG_N 3
`define SCC_FLAG_I 4
`define SCC_FLAG_H 5
// ==========================================
// Address decode
`define SCC_RAM_PAGE_HI 9'h000
`define SCC_PG_PORT_TMR 8'hF1
`define SCC_PG_SERIAL 8'hF2
`define SCC_PG_LINK 8'hF3
`define SCC_PG_PANEL 8'hF4
`define SCC_PG_FLAG 8'hF7
`define SCC_PG_BOOT_LO 8'hF8
`define SCC_PG_BUF_LO 8'h18
`define SCC_PG_BUF_HI 8'h7F
`define SCC_TMR_SUB 5'h10
// ==========================================
// Timer register layout
`define SCC_TMR_CR13 3'h0
`define SCC_TMR_CR2 3'h1
`define SCC_CR_HOLD 0
`define SCC_CR_SEL 0
`define SCC_CR_IE 6
`define SCC_CR_OE 7
`endif

/* File: design/scc_scratch_ram.v */
`timescale 1ns/1ps
`default_nettype none
module scc_scratch_ram (
	input wire clk_i,
	input wire wr_en_i,
	input wire [6:0] addr_i,
	input wire [7:0] wdata_i,
	output reg [7:0] rdata_o
);
	reg [7:0] mem [0:127];

	// No reset: contents are undefined at power-up
	always @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[addr_i] <= wdata_i;
		end
		rdata_o <= mem[addr_i];
	end
endmodule
`default_nettype wire

/* File: design/scc_proc_core.v */
// Functional notes
// RQ1 - E clock is oscillator divided by four
// RQ2 - Memory-ready low stretches E by half periods
// RQ3 - Unmasked IRQ stacks registers, vectors FFF8
// RQ4 - NMI stacks registers regardless, vectors FFFC
// RQ5 - Reset stops; restart from FFFE vector
// RQ6 - Reset sets interrupt mask flag
// RQ7 - Halt stops execution; pending events kept
// RQ8 - Halt or wait: bus available, buses released
// RQ9 - Valid address high only for real cycles
// RQ10 - Read/write high reads, low writes
// RQ11 - Push writes at SP, then decrements
// RQ12 - Pull increments SP, then reads
// RQ13 - Carry, overflow, zero, negative flags
// RQ14 - Half carry from bit 3 sets bit 5
// RQ15 - IRQ sets mask; bits 6,7 read one
// RQ16 - 128-byte scratch RAM at 0000-007F
// RQ17 - Scratch RAM answers only when enabled
// RQ18 - Decode pages F1, F2, F3; F0 unused
// RQ19 - Decode F4, F7, F8-FF, 18-7F
// RQ20 - Three 16-bit timers, controls, status
// RQ21 - Timer 2 counts timer 1 underflows
// RQ22 - Timer interrupt out; timer 3 line clock
// RQ23 - Timer at F18X; CR2 bit 0 selects
// RQ24 - Chip enables only with valid address
// RQ25 - PC changes only by step, jump, vector
`include "scc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module scc_proc_core (
	input wire REF_CLK_I,
	input wire RST_N_I,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [7:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	output wire [31:0] WB_DAT_O,
	output wire WB_ACK_O,
	output wire E_CLK_O,
	output wire [15:0] ADDR_O,
	output wire ADDR_OE_O,
	output wire [7:0] DATA_O,
	output wire DATA_OE_O,
	input wire [7:0] DATA_I,
	output wire RW_O,
	output wire VALID_ADDR_O,
	output wire BUS_AVAIL_O,
	input wire MEMORY_READY_IN_I,
	input wire IRQ_N_I,
	input wire NMI_N_I,
	input wire HALT_N_I,
	input wire SCRATCH_RAM_ENABLE_I,
	output wire CE_PORT_TIMER_O,
	output wire CE_SERIAL_O,
	output wire CE_LINK_O,
	output wire CE_PANEL_O,
	output wire CE_FLAG_O,
	output wire CE_BOOT_O,
	output wire CE_BUFFER_O,
	output wire TIMER_IRQ_O,
	output wire LINE_CLK_O
);
	localparam [2:0] ST_RESET = 3'h0;
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_INT = 3'h2;
	localparam [2:0] ST_CMD = 3'h3;
	localparam [2:0] ST_WAIT = 3'h4;

	function [6:0] decode_page;
		input [7:0] pg;
		begin
			decode_page = 7'h00;
			decode_page[0] = (pg == `SCC_PG_PORT_TMR);
			decode_page[1] = (pg == `SCC_PG_SERIAL);
			decode_page[2] = (pg == `SCC_PG_LINK);
			decode_page[3] = (pg == `SCC_PG_PANEL);
			decode_page[4] = (pg == `SCC_PG_FLAG);
			decode_page[5] = (pg >= `SCC_PG_BOOT_LO);
			decode_page[6] = (pg >= `SCC_PG_BUF_LO) && (pg <= `SCC_PG_BUF_HI);
		end
	endfunction

	function [31:0] merge_lanes;
		input [31:0] old;
		input [31:0] new_val;
		input [3:0] sel;
		integer k;
		begin
			merge_lanes = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (sel[k]) begin
					merge_lanes[8*k +: 8] = new_val[8*k +: 8];
				end
			end
		end
	endfunction

	// ==========================================
	// E clock divider with memory-ready stretch
	reg [1:0] phase_ff;
	reg stretch_ff;
	reg e_clk_ff;
	// Stretch only in E-high half, in pairs of oscillator cycles
	wire e_hold = (phase_ff == `SCC_PHASE_LAST) && (!MEMORY_READY_IN_I || stretch_ff); // RQ2
	wire e_end = (phase_ff == `SCC_PHASE_LAST) && !e_hold;
	wire [1:0] nxt_phase = e_hold ? phase_ff : phase_ff + 2'h1;

	always @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			phase_ff <= 2'h0;
			stretch_ff <= 1'b0;
			e_clk_ff <= 1'b0;
		end else begin
			phase_ff <= nxt_phase; // RQ1
			stretch_ff <= e_hold ? ~stretch_ff : 1'b0;
			e_clk_ff <= nxt_phase[1];
		end
	end

	// ==========================================
	// Processor state
	reg [2:0] state_ff;
	reg [3:0] step_ff;
	reg [15:0] vec_ff;
	reg [7:0] acc_a_ff;
	reg [7:0] acc_b_ff;
	reg [7:0] flags_ff;
	reg [15:0] sp_ff;
	reg [15:0] ix_ff;
	reg [15:0] pc_ff;
	reg [7:0] rdata_ff;
	reg [15:0] bus_addr_ff;
	reg [7:0] bus_wdata_ff;
	reg bus_rw_ff;
	reg vma_ff;
	reg [3:0] cmd_op_ff;
	reg [15:0] cmd_addr_ff;
	reg cmd_pend_ff;
	reg nmi_prev_ff;
	reg nmi_pend_ff;
	reg ack_ff;
	reg [31:0] wb_dat_ff;
	reg [7:0] push_byte;
	reg [7:0] tmr_q;
	reg [31:0] wb_rd;
	wire [7:0] ram_q;

	wire int_ram_sel = SCRATCH_RAM_ENABLE_I && (bus_addr_ff[15:7] == `SCC_RAM_PAGE_HI); // RQ16 RQ17
	wire tmr_sel = (bus_addr_ff[15:8] == `SCC_PG_PORT_TMR) && (bus_addr_ff[7:3] == `SCC_TMR_SUB); // RQ23
	wire [7:0] rd_byte = int_ram_sel ? ram_q : (tmr_sel ? tmr_q : DATA_I);
	wire bus_avail = (state_ff == ST_WAIT) || (!HALT_N_I && !vma_ff); // RQ8
	wire can_start = e_end && HALT_N_I && ((state_ff == ST_IDLE) || (state_ff == ST_WAIT)); // RQ7
	wire take_nmi = can_start && nmi_pend_ff; // RQ4
	wire take_irq = can_start && !nmi_pend_ff && !IRQ_N_I && !flags_ff[`SCC_FLAG_I]; // RQ3
	wire take_cmd = can_start && (state_ff == ST_IDLE) && !nmi_pend_ff && !take_irq && cmd_pend_ff;
	wire nmi_fall = nmi_prev_ff && !NMI_N_I;
	wire rd_done = e_end && vma_ff && bus_rw_ff;
	wire wr_done = e_end && vma_ff && !bus_rw_ff;

	// ==========================================
	// Arithmetic and flags
	wire [8:0] add_sum = {1'b0, acc_a_ff} + {1'b0, acc_b_ff};
	wire [8:0] sub_dif = {1'b0, acc_a_ff} - {1'b0, acc_b_ff};
	wire [4:0] half_sum = {1'b0, acc_a_ff[3:0]} + {1'b0, acc_b_ff[3:0]};
	wire add_v = (acc_a_ff[7] == acc_b_ff[7]) && (add_sum[7] != acc_a_ff[7]);
	wire sub_v = (acc_a_ff[7] != acc_b_ff[7]) && (sub_dif[7] != acc_a_ff[7]);
	wire [7:0] add_flags = {2'h3, half_sum[4], flags_ff[4], add_sum[7], add_sum[7:0] == 8'h00,
		add_v, add_sum[8]}; // RQ13 RQ14
	wire [7:0] sub_flags = {2'h3, flags_ff[5:4], sub_dif[7], sub_dif[7:0] == 8'h00,
		sub_v, sub_dif[8]}; // RQ13

	// Stack image order: PC low first, flags last
	always @* begin
		case (step_ff + 4'h1)
			4'h1: push_byte = pc_ff[15:8];
			4'h2: push_byte = ix_ff[7:0];
			4'h3: push_byte = ix_ff[15:8];
			4'h4: push_byte = acc_a_ff;
			4'h5: push_byte = acc_b_ff;
			4'h6: push_byte = flags_ff | `SCC_FLAGS_ONES;
			default: push_byte = pc_ff[7:0];
		endcase
	end

	// ==========================================
	// Register bus slave
	wire wb_req = WB_CYC_I && WB_STB_I && !ack_ff;
	wire wb_wr = WB_CYC_I && WB_STB_I && WB_WE_I && ack_ff;
	wire [7:0] wb_ofs = {WB_ADR_I[7:2], 2'h0};
	// Software state may only change while nothing is executing
	wire wb_idle = !cmd_pend_ff && (state_ff == ST_IDLE || state_ff == ST_WAIT);
	wire wb_cmd_wr = wb_wr && wb_idle && (wb_ofs == `SCC_OFS_CMD) && WB_SEL_I[0];
	wire [31:0] acc_word = {16'h0000, acc_b_ff, acc_a_ff};
	wire [31:0] cmd_word = {cmd_addr_ff, 12'h000, cmd_op_ff};
	wire [31:0] acc_new = merge_lanes(acc_word, WB_DAT_I, WB_SEL_I);
	wire [31:0] flg_new = merge_lanes({24'h0, flags_ff}, WB_DAT_I, WB_SEL_I);
	wire [31:0] sp_new = merge_lanes({16'h0, sp_ff}, WB_DAT_I, WB_SEL_I);
	wire [31:0] ix_new = merge_lanes({16'h0, ix_ff}, WB_DAT_I, WB_SEL_I);
	wire [31:0] cmd_new = merge_lanes(cmd_word, WB_DAT_I, WB_SEL_I);

	always @* begin
		case (wb_ofs)
			`SCC_OFS_CMD: wb_rd = {29'h0, state_ff == ST_WAIT, bus_avail, !wb_idle};
			`SCC_OFS_ACC: wb_rd = acc_word;
			`SCC_OFS_FLAGS: wb_rd = {24'h0, flags_ff | `SCC_FLAGS_ONES}; // RQ15
			`SCC_OFS_SP: wb_rd = {16'h0, sp_ff};
			`SCC_OFS_INDEX: wb_rd = {16'h0, ix_ff};
			`SCC_OFS_RDATA: wb_rd = {24'h0, rdata_ff};
			default: wb_rd = 32'h0000_0000;
		endcase
	end

	always @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ack_ff <= 1'b0;
			wb_dat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= wb_req;
			if (wb_req) begin
				wb_dat_ff <= wb_rd;
			end
		end
	end

	// ==========================================
	// Sequencer: one bus cycle per E period
	always @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_ff <= ST_RESET; // RQ5
			step_ff <= 4'h0;
			vec_ff <= `SCC_VEC_RST;
			acc_a_ff <= 8'h00;
			acc_b_ff <= 8'h00;
			flags_ff <= `SCC_FLAGS_RST; // RQ6
			sp_ff <= `SCC_SP_RST;
			ix_ff <= 16'h0000;
			pc_ff <= 16'h0000;
			rdata_ff <= 8'h00;
			bus_addr_ff <= 16'h0000;
			bus_wdata_ff <= 8'h00;
			bus_rw_ff <= 1'b1;
			vma_ff <= 1'b0;
			cmd_op_ff <= `SCC_OP_NOP;
			cmd_addr_ff <= 16'h0000;
			cmd_pend_ff <= 1'b0;
			nmi_prev_ff <= 1'b1;
			nmi_pend_ff <= 1'b0;
		end else begin
			nmi_prev_ff <= NMI_N_I;
			nmi_pend_ff <= nmi_fall || (nmi_pend_ff && !take_nmi); // RQ7
			cmd_pend_ff <= wb_cmd_wr || (cmd_pend_ff && !take_cmd);
			if (wb_cmd_wr) begin
				cmd_op_ff <= cmd_new[3:0];
				cmd_addr_ff <= cmd_new[31:16];
			end
			if (wb_wr && wb_idle) begin
				case (wb_ofs)
					`SCC_OFS_ACC: begin
						acc_a_ff <= acc_new[7:0];
						acc_b_ff <= acc_new[15:8];
					end
					`SCC_OFS_FLAGS: flags_ff <= flg_new[7:0] | `SCC_FLAGS_ONES;
					`SCC_OFS_SP: sp_ff <= sp_new[15:0];
					`SCC_OFS_INDEX: ix_ff <= ix_new[15:0];
					default: ;
				endcase
			end
			if (rd_done) begin
				rdata_ff <= rd_byte;
			end
			if (e_end) begin
				case (state_ff)
					ST_RESET: begin
						if (HALT_N_I) begin // RQ7
							state_ff <= ST_INT;
							step_ff <= 4'h7;
							vec_ff <= `SCC_VEC_RST; // RQ5
							bus_addr_ff <= `SCC_VEC_RST;
							bus_rw_ff <= 1'b1;
							vma_ff <= 1'b1;
						end
					end
					ST_IDLE, ST_WAIT: begin
						if (take_nmi || take_irq) begin
							state_ff <= ST_INT;
							step_ff <= 4'h0;
							vec_ff <= take_nmi ? `SCC_VEC_NMI : `SCC_VEC_IRQ; // RQ3 RQ4
							flags_ff[`SCC_FLAG_I] <= 1'b1; // RQ15
							bus_addr_ff <= sp_ff;
							bus_wdata_ff <= pc_ff[7:0];
							bus_rw_ff <= 1'b0;
							vma_ff <= 1'b1;
						end else if (take_cmd) begin
							case (cmd_op_ff)
								`SCC_OP_PUSH_A, `SCC_OP_PUSH_B: begin
									state_ff <= ST_CMD;
									bus_addr_ff <= sp_ff; // RQ11
									bus_wdata_ff <= (cmd_op_ff == `SCC_OP_PUSH_A) ? acc_a_ff : acc_b_ff;
									bus_rw_ff <= 1'b0; // RQ10
									vma_ff <= 1'b1; // RQ9
								end
								`SCC_OP_PULL_A, `SCC_OP_PULL_B: begin
									state_ff <= ST_CMD;
									bus_addr_ff <= sp_ff + 16'h0001; // RQ12
									bus_rw_ff <= 1'b1; // RQ10
									vma_ff <= 1'b1;
								end
								`SCC_OP_LOAD, `SCC_OP_STEP: begin
									state_ff <= ST_CMD;
									bus_addr_ff <= (cmd_op_ff == `SCC_OP_STEP) ? pc_ff : cmd_addr_ff;
									bus_rw_ff <= 1'b1;
									vma_ff <= 1'b1;
								end
								`SCC_OP_STORE: begin
									state_ff <= ST_CMD;
									bus_addr_ff <= cmd_addr_ff;
									bus_wdata_ff <= acc_a_ff;
									bus_rw_ff <= 1'b0;
									vma_ff <= 1'b1;
								end
								`SCC_OP_ADD: begin
									acc_a_ff <= add_sum[7:0];
									flags_ff <= add_flags; // RQ13 RQ14
								end
								`SCC_OP_SUB: begin
									acc_a_ff <= sub_dif[7:0];
									flags_ff <= sub_flags; // RQ13
								end
								`SCC_OP_JUMP: pc_ff <= cmd_addr_ff; // RQ25
								`SCC_OP_WAIT: state_ff <= ST_WAIT; // RQ8
								`SCC_OP_CLI: flags_ff[`SCC_FLAG_I] <= 1'b0;
								`SCC_OP_SEI: flags_ff[`SCC_FLAG_I] <= 1'b1;
								default: ;
							endcase
						end
					end
					ST_INT: begin
						if (step_ff < 4'h6) begin
							step_ff <= step_ff + 4'h1;
							sp_ff <= sp_ff - 16'h0001;
							bus_addr_ff <= sp_ff - 16'h0001;
							bus_wdata_ff <= push_byte;
						end else if (step_ff == 4'h6) begin
							step_ff <= 4'h7;
							sp_ff <= sp_ff - 16'h0001;
							bus_addr_ff <= vec_ff;
							bus_rw_ff <= 1'b1;
						end else if (step_ff == 4'h7) begin
							step_ff <= 4'h8;
							pc_ff[15:8] <= rd_byte; // RQ25
							bus_addr_ff <= vec_ff + 16'h0001;
						end else begin
							pc_ff[7:0] <= rd_byte; // RQ25
							vma_ff <= 1'b0;
							state_ff <= ST_IDLE;
						end
					end
					ST_CMD: begin
						case (cmd_op_ff)
							`SCC_OP_PUSH_A, `SCC_OP_PUSH_B: sp_ff <= sp_ff - 16'h0001; // RQ11
							`SCC_OP_PULL_A: begin
								sp_ff <= sp_ff + 16'h0001; // RQ12
								acc_a_ff <= rd_byte;
							end
							`SCC_OP_PULL_B: begin
								sp_ff <= sp_ff + 16'h0001; // RQ12
								acc_b_ff <= rd_byte;
							end
							`SCC_OP_LOAD: acc_a_ff <= rd_byte;
							`SCC_OP_STEP: pc_ff <= pc_ff + 16'h0001; // RQ25
							default: ;
						endcase
						vma_ff <= 1'b0;
						bus_rw_ff <= 1'b1;
						state_ff <= ST_IDLE;
					end
					default: state_ff <= ST_IDLE;
				endcase
			end
		end
	end

	scc_scratch_ram u_ram (
		.clk_i(REF_CLK_I),
		.wr_en_i(wr_done && int_ram_sel), // RQ17
		.addr_i(bus_addr_ff[6:0]),
		.wdata_i(bus_wdata_ff),
		.rdata_o(ram_q)
	);

	// ==========================================
	// Triple timer
	reg [7:0] cr1_ff;
	reg [7:0] cr2_ff;
	reg [7:0] cr3_ff;
	reg [7:0] msb_buf_ff;
	wire [2:0] tmr_reg = bus_addr_ff[2:0];
	wire tmr_wr = wr_done && tmr_sel;
	wire stat_clr = rd_done && tmr_sel && (tmr_reg == `SCC_TMR_CR2);
	wire hold_all = cr1_ff[`SCC_CR_HOLD];
	wire [2:0] under;
	wire [2:0] tmr_out;
	wire [2:0] stat;
	wire [47:0] cnt_all;
	wire [2:0] tmr_ie = {cr3_ff[`SCC_CR_IE], cr2_ff[`SCC_CR_IE], cr1_ff[`SCC_CR_IE]};

	always @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cr1_ff <= 8'h01;
			cr2_ff <= 8'h00;
			cr3_ff <= 8'h00;
			msb_buf_ff <= 8'h00;
		end else if (tmr_wr) begin
			case (tmr_reg)
				`SCC_TMR_CR13: begin
					if (cr2_ff[`SCC_CR_SEL]) begin // RQ23
						cr1_ff <= bus_wdata_ff;
					end else begin
						cr3_ff <= bus_wdata_ff;
					end
				end
				`SCC_TMR_CR2: cr2_ff <= bus_wdata_ff;
				3'h2, 3'h4, 3'h6: msb_buf_ff <= bus_wdata_ff;
				default: ;
			endcase
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_tmr
			reg [15:0] cnt_ff;
			reg [15:0] latch_ff;
			reg out_ff;
			reg stat_ff;
			// Timer 2 advances on timer 1 underflow, the others on E
			wire clk_en = (gi == 1) ? under[0] : e_end; // RQ21 RQ22
			wire [2:0] lsb_idx = (gi == 0) ? 3'h3 : ((gi == 1) ? 3'h5 : 3'h7);
			wire load = tmr_wr && (tmr_reg == lsb_idx);
			assign under[gi] = clk_en && !hold_all && (cnt_ff == 16'h0000);
			assign tmr_out[gi] = out_ff;
			assign stat[gi] = stat_ff;
			assign cnt_all[16*gi +: 16] = cnt_ff;
			always @(posedge REF_CLK_I or negedge RST_N_I) begin
				if (!RST_N_I) begin
					cnt_ff <= 16'hFFFF;
					latch_ff <= 16'hFFFF;
					out_ff <= 1'b0;
					stat_ff <= 1'b0;
				end else begin
					stat_ff <= under[gi] || (stat_ff && !stat_clr); // RQ20
					if (load) begin
						latch_ff <= {msb_buf_ff, bus_wdata_ff};
						cnt_ff <= {msb_buf_ff, bus_wdata_ff};
					end else if (clk_en && !hold_all) begin
						if (cnt_ff == 16'h0000) begin
							cnt_ff <= latch_ff;
							out_ff <= ~out_ff;
						end else begin
							cnt_ff <= cnt_ff - 16'h0001;
						end
					end
				end
			end
		end
	endgenerate

	always @* begin
		case (tmr_reg)
			`SCC_TMR_CR2: tmr_q = {|(stat & tmr_ie), 4'h0, stat}; // RQ20
			3'h2: tmr_q = cnt_all[15:8];
			3'h3: tmr_q = cnt_all[7:0];
			3'h4: tmr_q = cnt_all[31:24];
			3'h5: tmr_q = cnt_all[23:16];
			3'h6: tmr_q = cnt_all[47:40];
			3'h7: tmr_q = cnt_all[39:32];
			default: tmr_q = 8'h00;
		endcase
	end

	// ==========================================
	// Outputs
	wire [6:0] ce = vma_ff ? decode_page(bus_addr_ff[15:8]) : 7'h00; // RQ18 RQ19 RQ24
	assign CE_PORT_TIMER_O = ce[0];
	assign CE_SERIAL_O = ce[1];
	assign CE_LINK_O = ce[2];
	assign CE_PANEL_O = ce[3];
	assign CE_FLAG_O = ce[4];
	assign CE_BOOT_O = ce[5];
	assign CE_BUFFER_O = ce[6];
	assign TIMER_IRQ_O = |(stat & tmr_ie); // RQ22
	assign LINE_CLK_O = tmr_out[2] && cr3_ff[`SCC_CR_OE]; // RQ22
	assign E_CLK_O = e_clk_ff;
	assign ADDR_O = bus_addr_ff;
	assign ADDR_OE_O = !bus_avail; // RQ8
	assign DATA_O = bus_wdata_ff;
	assign DATA_OE_O = vma_ff && !bus_rw_ff && !bus_avail;
	assign RW_O = bus_rw_ff;
	assign VALID_ADDR_O = vma_ff; // RQ9
	assign BUS_AVAIL_O = bus_avail;
	assign WB_DAT_O = wb_dat_ff;
	assign WB_ACK_O = ack_ff;
endmodule
`default_nettype wire

/* File: testbench/scc_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module scc_core_asserts (
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	input wire logic E_CLK_O,
	input wire logic [15:0] ADDR_O,
	input wire logic ADDR_OE_O,
	input wire logic DATA_OE_O,
	input wire logic RW_O,
	input wire logic VALID_ADDR_O,
	input wire logic BUS_AVAIL_O,
	input wire logic MEMORY_READY_IN_I,
	input wire logic HALT_N_I,
	input wire logic CE_PORT_TIMER_O,
	input wire logic CE_SERIAL_O,
	input wire logic CE_LINK_O,
	input wire logic CE_PANEL_O,
	input wire logic CE_FLAG_O,
	input wire logic CE_BOOT_O,
	input wire logic CE_BUFFER_O
);
	// ==========================================
	// Bus timing and decode
	wire [7:0] pg = ADDR_O[15:8];
	default clocking @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	sequence s_vec_hi(logic [15:0] v);
		$changed(ADDR_O) && VALID_ADDR_O && ADDR_O == v;
	endsequence
	sequence s_vec_lo(logic [15:0] v);
		RW_O ##[1:12] (VALID_ADDR_O && RW_O && ADDR_O == v);
	endsequence
	a_e_low: assert property ($fell(E_CLK_O) |=> !E_CLK_O ##1 E_CLK_O)
		else $error("E low phase not two cycles");
	a_e_stretch: assert property (E_CLK_O && !MEMORY_READY_IN_I |=> E_CLK_O)
		else $error("E ended while memory not ready");
	a_irq_vector: assert property (s_vec_hi(16'hFFF8) |-> s_vec_lo(16'hFFF9))
		else $error("maskable vector pair broken");
	a_nmi_vector: assert property (s_vec_hi(16'hFFFC) |-> s_vec_lo(16'hFFFD))
		else $error("nonmaskable vector pair broken");
	a_rst_vector: assert property (s_vec_hi(16'hFFFE) |-> s_vec_lo(16'hFFFF))
		else $error("restart vector pair broken");
	a_halt_stop: assert property (!HALT_N_I && !VALID_ADDR_O |=> !VALID_ADDR_O)
		else $error("cycle started while halted");
	a_ba_float: assert property (BUS_AVAIL_O |-> !ADDR_OE_O && !DATA_OE_O && !VALID_ADDR_O)
		else $error("bus driven while available");
	a_addr_stable: assert property (E_CLK_O && $past(E_CLK_O) |-> $stable(ADDR_O) && $stable(VALID_ADDR_O))
		else $error("address moved inside E cycle");
	a_rw_data: assert property (VALID_ADDR_O |-> DATA_OE_O == !RW_O)
		else $error("data drive disagrees with direction");
	a_ce_valid: assert property ((CE_PORT_TIMER_O || CE_SERIAL_O || CE_LINK_O || CE_PANEL_O
		|| CE_FLAG_O || CE_BOOT_O || CE_BUFFER_O) |-> VALID_ADDR_O)
		else $error("enable without valid address");
	a_dec_io: assert property (VALID_ADDR_O |-> CE_PORT_TIMER_O == (pg == 8'hF1)
		&& CE_SERIAL_O == (pg == 8'hF2) && CE_LINK_O == (pg == 8'hF3))
		else $error("io page decode wrong");
	a_dec_mem: assert property (VALID_ADDR_O |-> CE_PANEL_O == (pg == 8'hF4)
		&& CE_FLAG_O == (pg == 8'hF7) && CE_BOOT_O == (pg >= 8'hF8)
		&& CE_BUFFER_O == (pg >= 8'h18 && pg <= 8'h7F))
		else $error("memory page decode wrong");
endmodule
bind scc_proc_core scc_core_asserts u_chk (.*);
`default_nettype wire

/* File: testbench/scc_bus_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module scc_bus_partner (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic e_clk_i,
	input wire logic [15:0] addr_i,
	input wire logic rw_i,
	input wire logic valid_i,
	input wire logic data_oe_i,
	input wire logic [7:0] wdata_i,
	input wire logic slow_i,
	output logic [7:0] rdata_o,
	output logic ready_o
);
	// ==========================================
	// Local bus memory
	logic [7:0] mem [0:65535];
	logic [7:0] last_ff;
	logic [1:0] cnt_ff;
	// Released bus never repeats the last byte
	assign rdata_o = (valid_i && rw_i) ? mem[addr_i] : ~last_ff;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_ff <= 8'h00;
			cnt_ff <= 2'h0;
			ready_o <= 1'b1;
		end else begin
			if (valid_i && rw_i)
				last_ff <= mem[addr_i];
			if (valid_i && !rw_i && data_oe_i)
				mem[addr_i] <= wdata_i;
			if (!e_clk_i) begin
				cnt_ff <= 2'h0;
				ready_o <= 1'b1;
			end else if (slow_i && valid_i && cnt_ff < 2'h2) begin
				cnt_ff <= cnt_ff + 2'h1;
				ready_o <= 1'b0;
			end else
				ready_o <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/test_scc_processor_bus_decode_timer.sv */
`include "scc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module test_scc_processor_bus_decode_timer;
	logic clk, rst_n, cyc, stb, we, halt_n, irq_n, nmi_n, ram_en, slow, clr;
	logic ack, e_clk, addr_oe, data_oe, rw, valid, ba, rdy;
	logic [7:0] adr, data_o, data_i;
	logic [3:0] sel;
	logic [31:0] wdat, r, dat_o;
	logic [15:0] addr;
	logic [6:0] ce, seen_ff;
	logic [7:0] pgs [14] = '{8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF7, 8'hF8, 8'hFF,
		8'h7F, 8'h17, 8'h80, 8'h00, 8'h18};
	logic [6:0] ces [14] = '{7'h00, 7'h40, 7'h20, 7'h10, 7'h08, 7'h00, 7'h04, 7'h02, 7'h02,
		7'h01, 7'h00, 7'h00, 7'h00, 7'h01};
	logic [7:0] alu_a [2] = '{8'h7F, 8'hFF};
	logic [7:0] alu_r [2] = '{8'h80, 8'h00};
	logic [7:0] alu_f [2] = '{8'hFA, 8'hF5};
	int mismatches, checks;
	scc_proc_core DUT (.REF_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
		.WB_ACK_O(ack), .E_CLK_O(e_clk), .ADDR_O(addr), .ADDR_OE_O(addr_oe), .DATA_O(data_o),
		.DATA_OE_O(data_oe), .DATA_I(data_i), .RW_O(rw), .VALID_ADDR_O(valid), .BUS_AVAIL_O(ba),
		.MEMORY_READY_IN_I(rdy), .IRQ_N_I(irq_n), .NMI_N_I(nmi_n), .HALT_N_I(halt_n),
		.SCRATCH_RAM_ENABLE_I(ram_en), .CE_PORT_TIMER_O(ce[6]), .CE_SERIAL_O(ce[5]),
		.CE_LINK_O(ce[4]), .CE_PANEL_O(ce[3]), .CE_FLAG_O(ce[2]), .CE_BOOT_O(ce[1]),
		.CE_BUFFER_O(ce[0]), .TIMER_IRQ_O(), .LINE_CLK_O());
	scc_bus_partner PRT (.clk_i(clk), .rst_n_i(rst_n), .e_clk_i(e_clk), .addr_i(addr), .rw_i(rw),
		.valid_i(valid), .data_oe_i(data_oe), .wdata_i(data_o), .slow_i(slow), .rdata_o(data_i),
		.ready_o(rdy));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
		seen_ff <= clr ? 7'h00 : (valid ? seen_ff | ce : seen_ff);
	// ==========================================
	// Access tasks
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic hang();
		mismatches++;
		$display("mismatch timeout at %0t", $time);
		final_report();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50)
			hang();
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		int n;
		n = 0;
		do begin
			wb(1'b0, a, 32'h0);
			n++;
		end while ((r & m) !== e && n < 60);
		chk(r & m, e);
	endtask
	task automatic op(input logic [3:0] c, input logic [15:0] a, input bit poll);
		wreg(`SCC_OFS_CMD, 32'h1, 32'h0);
		wb(1'b1, `SCC_OFS_CMD, {a, 12'h000, c});
		if (poll)
			wreg(`SCC_OFS_CMD, 32'h1, 32'h0);
	endtask
	task automatic wait_ba();
		int n;
		n = 0;
		while (ba !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n >= 200)
			hang();
	endtask
	task automatic pulse_nmi();
		nmi_n <= 1'b0;
		repeat (2) @(posedge clk);
		nmi_n <= 1'b1;
	endtask
	// ==========================================
	// Scenarios
	initial begin
		mismatches = 0;
		checks = 0;
		{rst_n, cyc, stb, we, adr, wdat, slow, clr} = '0;
		{halt_n, irq_n, nmi_n, ram_en, sel} = '1;
		repeat (2) @(posedge clk);
		{PRT.mem[16'hFFFE], PRT.mem[16'hFFFF], PRT.mem[16'h1234]} = {8'h12, 8'h34, 8'hA5};
		{PRT.mem[16'hFFFC], PRT.mem[16'hFFFD], PRT.mem[16'h2000]} = {8'h20, 8'h00, 8'hC3};
		{PRT.mem[16'hFFF8], PRT.mem[16'hFFF9], PRT.mem[16'h3000]} = {8'h30, 8'h00, 8'h96};
		PRT.mem[16'h1805] = 8'h5A;
		PRT.mem[16'h0070] = 8'h00;
		repeat (18) @(posedge clk);
		rst_n <= 1'b1;
		wreg(`SCC_OFS_FLAGS, 32'hFF, 32'hD0);
		wreg(8'h20, 32'hFFFFFFFF, 32'h0);
		op(`SCC_OP_STEP, 16'h0, 1'b1);
		wreg(`SCC_OFS_RDATA, 32'hFF, 32'hA5);
		$display("test reset done");
		for (int i = 0; i < 2; i++) begin
			wb(1'b1, `SCC_OFS_ACC, {16'h0, 8'h01, alu_a[i]});
			op(`SCC_OP_ADD, 16'h0, 1'b1);
			wreg(`SCC_OFS_ACC, 32'hFF, {24'h0, alu_r[i]});
			wreg(`SCC_OFS_FLAGS, 32'hFF, {24'h0, alu_f[i]});
		end
		wb(1'b1, `SCC_OFS_ACC, 32'h0100);
		op(`SCC_OP_SUB, 16'h0, 1'b1);
		wreg(`SCC_OFS_ACC, 32'hFF, 32'hFF);
		wreg(`SCC_OFS_FLAGS, 32'h0F, 32'h09);
		wb(1'b1, `SCC_OFS_FLAGS, 32'h0);
		wreg(`SCC_OFS_FLAGS, 32'hFF, 32'hC0);
		op(`SCC_OP_SEI, 16'h0, 1'b1);
		$display("test flags done");
		wb(1'b1, `SCC_OFS_SP, 32'h70);
		wb(1'b1, `SCC_OFS_ACC, 32'hAB);
		op(`SCC_OP_PUSH_A, 16'h0, 1'b1);
		wreg(`SCC_OFS_SP, 32'hFFFF, 32'h6F);
		ram_en <= 1'b0;
		wb(1'b1, `SCC_OFS_SP, 32'h70);
		wb(1'b1, `SCC_OFS_ACC, 32'h11);
		op(`SCC_OP_PUSH_A, 16'h0, 1'b1);
		chk({24'h0, PRT.mem[16'h0070]}, 32'h11);
		ram_en <= 1'b1;
		wb(1'b1, `SCC_OFS_SP, 32'h6F);
		op(`SCC_OP_PULL_B, 16'h0, 1'b1);
		wreg(`SCC_OFS_SP, 32'hFFFF, 32'h70);
		ram_en <= 1'b0;
		wb(1'b1, `SCC_OFS_SP, 32'h6F);
		op(`SCC_OP_PULL_A, 16'h0, 1'b1);
		wreg(`SCC_OFS_ACC, 32'hFFFF, 32'hAB11);
		ram_en <= 1'b1;
		$display("test stack done");
		for (int i = 0; i < 14; i++) begin
			clr <= 1'b1;
			@(posedge clk);
			clr <= 1'b0;
			op(`SCC_OP_LOAD, {pgs[i], 8'h05}, 1'b1);
			chk({25'h0, seen_ff}, {25'h0, ces[i]});
		end
		wreg(`SCC_OFS_ACC, 32'hFF, 32'h5A);
		op(`SCC_OP_LOAD, 16'hF181, 1'b1);
		wreg(`SCC_OFS_ACC, 32'hFF, 32'h00);
		$display("test decode done");
		wb(1'b1, `SCC_OFS_SP, 32'h70);
		halt_n <= 1'b0;
		wait_ba();
		wreg(`SCC_OFS_CMD, 32'h2, 32'h2);
		chk({31'h0, addr_oe}, 32'h0);
		pulse_nmi();
		repeat (20) @(posedge clk);
		wreg(`SCC_OFS_SP, 32'hFFFF, 32'h70);
		halt_n <= 1'b1;
		wreg(`SCC_OFS_SP, 32'hFFFF, 32'h69);
		op(`SCC_OP_STEP, 16'h0, 1'b1);
		wreg(`SCC_OFS_RDATA, 32'hFF, 32'hC3);
		irq_n <= 1'b0;
		repeat (40) @(posedge clk);
		wreg(`SCC_OFS_SP, 32'hFFFF, 32'h69);
		op(`SCC_OP_CLI, 16'h0, 1'b0);
		wreg(`SCC_OFS_SP, 32'hFFFF, 32'h62);
		irq_n <= 1'b1;
		wreg(`SCC_OFS_FLAGS, 32'h10, 32'h10);
		op(`SCC_OP_STEP, 16'h0, 1'b1);
		wreg(`SCC_OFS_RDATA, 32'hFF, 32'h96);
		$display("test halt and interrupts done");
		op(`SCC_OP_WAIT, 16'h0, 1'b0);
		wait_ba();
		wreg(`SCC_OFS_CMD, 32'h6, 32'h6);
		pulse_nmi();
		wreg(`SCC_OFS_SP, 32'hFFFF, 32'h5B);
		slow <= 1'b1;
		op(`SCC_OP_STEP, 16'h0, 1'b1);
		wreg(`SCC_OFS_RDATA, 32'hFF, 32'hC3);
		slow <= 1'b0;
		$display("test wait and slow memory done");
		final_report();
	end
endmodule
`default_nettype wire
